// ### design/irp_field_reg.sv
// A register field loaded by software or by the block's own logic.
// Assumes a synchronous clock enable; the hardware load has priority.
module irp_field_reg
    import irp_pkg::*;
#(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         ce_i,
    input  wire logic         sw_we_i,
    input  wire logic [W-1:0] sw_d_i,
    input  wire logic         hw_we_i,
    input  wire logic [W-1:0] hw_d_i,
    output logic      [W-1:0] q_o
);

    // ==========================================================
    // Storage
    // ==========================================================
    logic [W-1:0] field_r;
    logic [W-1:0] field_nxt;

    // Hardware load wins so a completing access is never lost.
    assign field_nxt = hw_we_i ? hw_d_i : sw_d_i;

    // The field holds unless one of the two loads is active.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            field_r <= RST;
        end else if (ce_i && (hw_we_i || sw_we_i)) begin
            field_r <= field_nxt;
        end
    end

    assign q_o = field_r;

endmodule // irp_field_reg

// ### design/irp_indirect_port.sv
// Indirect access port into the controller's internal RAMs.
// Assumes a synchronous register port and a RAM that acks requests.
// What this block does
// - Read-only ready flag, reads one after reset.
// - Read sets ready only after word captured.
// - Ready low while busy, high when idle.
// - Four-bit selector, reset zero; code one hash.
// - A command write while idle starts one RAM access; reserved codes skip the RAM.
// - Command one writes, zero reads; resets zero.
// - Fourteen-bit word address, upper bits read zero.
// - Data word feeds writes, receives reads, resets zero.
//
// The implementer's own choice: the address-and-strobe port.
module irp_indirect_port
    import irp_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    input  wire irp_bus_s          bus_i,
    output logic      [DATA_W-1:0] rdata_o,
    output logic                   access_done_flag_o,
    output logic                   ram_req_o,
    output irp_ram_req_s           ram_cmd_o,
    input  wire logic              ram_ack_i,
    input  wire logic [DATA_W-1:0] ram_rdata_i
);

    // ==========================================================
    // Declarations
    // ==========================================================
    irp_state_e        state_r;
    irp_state_e        state_nxt;
    logic              ready_r;
    logic              ready_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    logic [SEL_W-1:0]  sel_q;
    logic [WADR_W-1:0] addr_q;
    logic [DATA_W-1:0] word_q;
    logic [0:0]        cmd_q;

    logic              hit_select;
    logic              hit_command;
    logic              hit_address;
    logic              hit_word;
    logic              hit_any;
    logic              idle;
    logic              wr_select;
    logic              wr_command;
    logic              wr_address;
    logic              wr_word;
    logic              start;
    logic              start_ram;
    logic              start_skip;
    logic              sel_valid;
    logic              ram_done;
    logic              skip_done;
    logic              finish;
    logic              finish_read;
    logic              word_hw_we;
    logic [DATA_W-1:0] word_hw_d;
    irp_ram_req_s      ram_cmd;

    logic [DATA_W-1:0] rd_select;
    logic [DATA_W-1:0] rd_command;
    logic [DATA_W-1:0] rd_address;
    logic [DATA_W-1:0] rd_word;

    // ==========================================================
    // Address decode
    // ==========================================================

    // One compare per mapped offset; anything else is unmapped.
    // The full byte offset is compared, so an access that is off by
    // a byte or two lands nowhere instead of aliasing a register.
    assign hit_select  = (bus_i.addr == OFS_SELECT);
    assign hit_command = (bus_i.addr == OFS_COMMAND);
    assign hit_address = (bus_i.addr == OFS_ADDRESS);
    assign hit_word    = (bus_i.addr == OFS_WORD);
    assign hit_any     = hit_select || hit_command
                      || hit_address || hit_word;

    // ==========================================================
    // Write qualification
    // ==========================================================

    // The port only accepts new settings while it is idle.
    assign idle = (state_r == IRP_ST_IDLE);

    // Writes to fields are dropped while an access runs.
    // Blocking them keeps selector, address and word steady under
    // a running access, and a second command cannot queue up behind
    // the first one.
    assign wr_select  = bus_i.wr && hit_select  && idle;
    assign wr_address = bus_i.wr && hit_address && idle;
    assign wr_word    = bus_i.wr && hit_word    && idle;
    assign wr_command = bus_i.wr && hit_command && idle;

    // Every accepted command write starts exactly one access.
    assign start = wr_command;

    // ==========================================================
    // Selector check
    // ==========================================================

    // Reserved codes have no RAM behind them and never reach it.
    // Codes above the last mapped one are reserved as well, so the
    // check is a range test with one hole in it.
    assign sel_valid = (sel_q <= SEL_TX_USB_BUF)
                    && (sel_q != SEL_RESERVED6);

    // Valid codes go to the RAM, reserved ones finish locally.
    assign start_ram  = start && sel_valid;
    assign start_skip = start && !sel_valid;

    // ==========================================================
    // Request formed from the fields as they stand
    // ==========================================================

    // The direction comes from the bit being written now.
    // Taking it from the bus rather than from the stored bit saves a
    // cycle; the stored copy only steers the completion afterwards.
    always_comb begin
        ram_cmd       = '0;
        ram_cmd.we    = bus_i.wdata[WRITE_BIT];
        ram_cmd.sel   = sel_q;
        ram_cmd.addr  = addr_q;
        ram_cmd.wdata = word_q;
    end

    // ==========================================================
    // RAM handshake
    // ==========================================================

    // The request flops live here and drive the RAM directly.
    // The command is copied at start, so the RAM sees one frozen
    // request until its ack, whatever the bus does meanwhile.
    irp_ram_if u_ram_if (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .start_i   (start_ram),
        .cmd_i     (ram_cmd),
        .ack_i     (ram_ack_i),
        .done_o    (ram_done),
        .req_o     (ram_req_o),
        .cmd_o     (ram_cmd_o)
    );

    // ==========================================================
    // Completion
    // ==========================================================

    // A RAM ack only completes the access in the busy state.
    // A stray ack while idle or skipping is ignored, since the
    // request flop is low then and no access can finish twice.
    assign skip_done = (state_r == IRP_ST_SKIP);
    assign finish    = ((state_r == IRP_ST_BUSY) && ram_done)
                    || skip_done;

    // A completing read loads the word register.
    assign finish_read = finish && (cmd_q == 1'b0);

    // Reserved codes read back as zero.
    // The word load and the ready flag share one edge, so a poll
    // that sees ready always finds the fetched word in place.
    assign word_hw_we = finish_read;
    assign word_hw_d  = skip_done ? '0 : ram_rdata_i;

    // ==========================================================
    // Register fields
    // ==========================================================

    // RAM selector, reset to the receive buffer code.
    // Software alone writes it; hardware never changes the choice.
    irp_field_reg #(
        .W   (SEL_W),
        .RST (SEL_RST)
    ) u_sel (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .sw_we_i   (wr_select),
        .sw_d_i    (bus_i.wdata[SEL_W-1:0]),
        .hw_we_i   (1'b0),
        .hw_d_i    (SEL_RST),
        .q_o       (sel_q)
    );

    // Direction bit; it stores the last value software wrote while idle.
    irp_field_reg #(
        .W   (1),
        .RST (CMD_RST)
    ) u_cmd (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .sw_we_i   (wr_command),
        .sw_d_i    (bus_i.wdata[WRITE_BIT]),
        .hw_we_i   (1'b0),
        .hw_d_i    (CMD_RST),
        .q_o       (cmd_q)
    );

    // Word address within the selected RAM.
    // Only the low fourteen bits are stored; the rest read zero.
    irp_field_reg #(
        .W   (WADR_W),
        .RST (ADDR_RST)
    ) u_addr (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .sw_we_i   (wr_address),
        .sw_d_i    (bus_i.wdata[WADR_W-1:0]),
        .hw_we_i   (1'b0),
        .hw_d_i    (ADDR_RST),
        .q_o       (addr_q)
    );

    // Data word; a finishing read overwrites it.
    // Hardware wins a clash, though busy blocks software anyway.
    irp_field_reg #(
        .W   (DATA_W),
        .RST (WORD_RST)
    ) u_word (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .sw_we_i   (wr_word),
        .sw_d_i    (bus_i.wdata),
        .hw_we_i   (word_hw_we),
        .hw_d_i    (word_hw_d),
        .q_o       (word_q)
    );

    // ==========================================================
    // Access sequencer
    // ==========================================================

    // Idle waits for a command; busy waits for the RAM's ack.
    // The skip state gives reserved codes a one-cycle busy pulse, so
    // software sees the same ready handshake for every selector. A
    // read that ends here loads the word register at the same edge.
    always_comb begin
        state_nxt = state_r;
        ready_nxt = ready_r;
        case (state_r)
            IRP_ST_IDLE: begin
                if (start_ram) begin
                    state_nxt = IRP_ST_BUSY;
                    ready_nxt = 1'b0;
                end else if (start_skip) begin
                    state_nxt = IRP_ST_SKIP;
                    ready_nxt = 1'b0;
                end
            end
            IRP_ST_BUSY: begin
                if (ram_done) begin
                    state_nxt = IRP_ST_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            IRP_ST_SKIP: begin
                state_nxt = IRP_ST_IDLE;
                ready_nxt = 1'b1;
            end
            default: begin
                state_nxt = IRP_ST_IDLE;
                ready_nxt = READY_RST;
            end
        endcase
    end

    // State and ready flag; the flag starts out set.
    // A low clock enable freezes both, together with every field.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= IRP_ST_IDLE;
            ready_r <= READY_RST;
        end else if (ce_i) begin
            state_r <= state_nxt;
            ready_r <= ready_nxt;
        end
    end

    // ==========================================================
    // Read-back images
    // ==========================================================

    // Reserved bits of every register read as zero.
    // The ready bit is read-only: no write path reaches it.
    always_comb begin
        rd_select            = '0;
        rd_select[READY_BIT] = ready_r;
        rd_select[SEL_W-1:0] = sel_q;
        rd_command           = '0;
        rd_command[WRITE_BIT] = cmd_q[0];
        rd_address           = '0;
        rd_address[WADR_W-1:0] = addr_q;
        rd_word              = word_q;
    end

    // ==========================================================
    // Read data return
    // ==========================================================

    // Unmapped offsets and idle cycles return zero.
    // Reads are served even while busy, so software can poll ready.
    always_comb begin
        rdata_nxt = '0;
        if (bus_i.rd && hit_any) begin
            case (1'b1)
                hit_select:  rdata_nxt = rd_select;
                hit_command: rdata_nxt = rd_command;
                hit_address: rdata_nxt = rd_address;
                hit_word:    rdata_nxt = rd_word;
                default:     rdata_nxt = '0;
            endcase
        end
    end

    // Read data stand for the one cycle after the strobe.
    // Clearing them otherwise keeps stale words off the bus.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= '0;
        end else if (ce_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    // Both outputs come straight from flops.
    // The request outputs come from flops inside the handshake.
    assign rdata_o            = rdata_r;
    assign access_done_flag_o = ready_r;

endmodule // irp_indirect_port

// ### design/irp_pkg.sv
// Constants, register map and carrier types for the indirect RAM port.
// Assumes one 40 MHz clock and a byte-addressed register port.
package irp_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int unsigned BUS_AW = 8;
    localparam int unsigned SEL_W  = 4;
    localparam int unsigned WADR_W = 14;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam logic [BUS_AW-1:0] OFS_SELECT  = 8'h24;
    localparam logic [BUS_AW-1:0] OFS_COMMAND = 8'h28;
    localparam logic [BUS_AW-1:0] OFS_ADDRESS = 8'h2C;
    localparam logic [BUS_AW-1:0] OFS_WORD    = 8'h30;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int unsigned READY_BIT = 31;
    localparam int unsigned WRITE_BIT = 0;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic [SEL_W-1:0]  SEL_RST   = 4'h0;
    localparam logic [WADR_W-1:0] ADDR_RST  = 14'h0000;
    localparam logic [DATA_W-1:0] WORD_RST  = 32'h0000_0000;
    localparam logic [0:0]        CMD_RST   = 1'h0;
    localparam logic              READY_RST = 1'b1;

    // ==========================================================
    // RAM selector codes; codes above the last one are reserved
    // ==========================================================
    localparam logic [SEL_W-1:0] SEL_RX_USB_BUF = 4'h0;
    localparam logic [SEL_W-1:0] SEL_VLAN_HASH  = 4'h1;
    localparam logic [SEL_W-1:0] SEL_LARGE_SEND = 4'h2;
    localparam logic [SEL_W-1:0] SEL_FIFO_RX    = 4'h3;
    localparam logic [SEL_W-1:0] SEL_FIFO_TX    = 4'h4;
    localparam logic [SEL_W-1:0] SEL_DESCRIPTOR = 4'h5;
    localparam logic [SEL_W-1:0] SEL_RESERVED6  = 4'h6;
    localparam logic [SEL_W-1:0] SEL_TX_USB_BUF = 4'h7;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        IRP_ST_IDLE,
        IRP_ST_BUSY,
        IRP_ST_SKIP
    } irp_state_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [BUS_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } irp_bus_s;

    typedef struct packed {
        logic              we;
        logic [SEL_W-1:0]  sel;
        logic [WADR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } irp_ram_req_s;

endpackage : irp_pkg

// ### design/irp_ram_if.sv
// Request side of the internal RAM handshake.
// Assumes the RAM answers a held request with a one-cycle ack.
module irp_ram_if
    import irp_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    input  wire logic              start_i,
    input  wire irp_ram_req_s      cmd_i,
    input  wire logic              ack_i,
    output logic                   done_o,
    output logic                   req_o,
    output irp_ram_req_s           cmd_o
);

    // ==========================================================
    // Request flops
    // ==========================================================
    logic         req_r;
    irp_ram_req_s cmd_r;

    // An ack only counts while a request is outstanding.
    assign done_o = req_r && ack_i;

    // The request stands from start until its ack.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_r <= 1'b0;
            cmd_r <= '0;
        end else if (ce_i) begin
            if (start_i) begin
                req_r <= 1'b1;
                cmd_r <= cmd_i;
            end else if (done_o) begin
                req_r <= 1'b0;
            end
        end
    end

    assign req_o = req_r;
    assign cmd_o = cmd_r;

endmodule // irp_ram_if

// ### test/irp_indirect_port_checker.sv
// Checker for the indirect RAM port, watching only the top-level ports.
// Assumes one clock, an active-low asynchronous reset and the bind below.
module irp_indirect_port_checker
    import irp_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              reset_n_i,
    input wire logic              ce_i,
    input wire irp_bus_s          bus_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              access_done_flag_o,
    input wire logic              ram_req_o,
    input wire irp_ram_req_s      ram_cmd_o,
    input wire logic              ram_ack_i,
    input wire logic [DATA_W-1:0] ram_rdata_i
);
    // ==========================================================
    // Port properties
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // A command write on an idle port must start an access.
    wire cmd_go = ce_i && bus_i.wr && bus_i.addr == OFS_COMMAND
                  && access_done_flag_o;

    a_req_means_busy: assert property (
        ram_req_o |-> !access_done_flag_o)
        else $error("request pending while the port reads ready");
    a_cmd_clears_flag: assert property (
        cmd_go |=> !access_done_flag_o)
        else $error("flag did not drop after a command write");
    a_req_holds_fields: assert property (
        ce_i && ram_req_o && !ram_ack_i |=> ram_req_o && $stable(ram_cmd_o))
        else $error("request or its fields moved before the ack");
    a_ack_ends_access: assert property (
        ce_i && ram_req_o && ram_ack_i |=> !ram_req_o && access_done_flag_o)
        else $error("ack did not end the access");
    a_write_direction: assert property (
        cmd_go && bus_i.wdata[0] |=> !ram_req_o || ram_cmd_o.we)
        else $error("write command issued a read");
    a_read_direction: assert property (
        cmd_go && !bus_i.wdata[0] |=> !ram_req_o || !ram_cmd_o.we)
        else $error("read command issued a write");
    a_req_has_cause: assert property (
        $rose(ram_req_o) |->
        $past(bus_i.wr) && $past(bus_i.addr) == OFS_COMMAND)
        else $error("request rose without a command write");
    a_flag_readback: assert property (
        ce_i && bus_i.rd && bus_i.addr == OFS_SELECT
        |=> rdata_o[READY_BIT] == $past(access_done_flag_o))
        else $error("ready bit read back wrong");
    a_addr_upper_zero: assert property (
        ce_i && bus_i.rd && bus_i.addr == OFS_ADDRESS
        |=> rdata_o[31:14] == 18'h0)
        else $error("address upper bits not zero");
    a_rdata_idle_zero: assert property (
        ce_i && !bus_i.rd |=> rdata_o == 32'h0)
        else $error("read data not zero outside a read answer");
    a_busy_cmd_ignored: assert property (
        ce_i && bus_i.wr && bus_i.addr == OFS_COMMAND
        && !access_done_flag_o |=> !$rose(ram_req_o))
        else $error("command write started an access while busy");
endmodule // irp_indirect_port_checker

bind irp_indirect_port irp_indirect_port_checker u_chk (
    .clk_i              (clk_i),
    .reset_n_i          (reset_n_i),
    .ce_i               (ce_i),
    .bus_i              (bus_i),
    .rdata_o            (rdata_o),
    .access_done_flag_o (access_done_flag_o),
    .ram_req_o          (ram_req_o),
    .ram_cmd_o          (ram_cmd_o),
    .ram_ack_i          (ram_ack_i),
    .ram_rdata_i        (ram_rdata_i)
);

// ### test/test_indirect_ram_access_port.sv
// Self-checking bench for the indirect RAM port.
// Assumes the bench plays both the register master and the RAM.
module test_indirect_ram_access_port;
    timeunit 1ns;
    timeprecision 1ps;
    import irp_pkg::*;

    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic              clk_i       = 1'b0;
    logic              reset_n_i   = 1'b0;
    logic              ce_i        = 1'b1;
    logic              ram_ack_i   = 1'b0;
    irp_bus_s          bus_i       = '0;
    logic [DATA_W-1:0] ram_rdata_i = 32'hFFFF_FFFF;
    logic [DATA_W-1:0] rdata_o;
    logic [DATA_W-1:0] v;
    logic              flag;
    logic              ram_req_o;
    irp_ram_req_s      ram_cmd_o;
    int                fails       = 0;
    int                checks_done = 0;

    // Clock of 25 ns period.
    always #12.5 clk_i = ~clk_i;

    irp_indirect_port dut (
        .clk_i              (clk_i),
        .reset_n_i          (reset_n_i),
        .ce_i               (ce_i),
        .bus_i              (bus_i),
        .rdata_o            (rdata_o),
        .access_done_flag_o (flag),
        .ram_req_o          (ram_req_o),
        .ram_cmd_o          (ram_cmd_o),
        .ram_ack_i          (ram_ack_i),
        .ram_rdata_i        (ram_rdata_i)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(string n, logic [81:0] s, logic [81:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        bus_i.wr    <= 1'b1;
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        @(posedge clk_i);
        bus_i.wr    <= 1'b0;
        bus_i.wdata <= ~d;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(logic [7:0] a);
        @(posedge clk_i);
        bus_i.rd   <= 1'b1;
        bus_i.addr <= a;
        @(posedge clk_i);
        bus_i.rd   <= 1'b0;
        #1 v = rdata_o;
    endtask

    // The RAM answers a held request after n + 1 idle cycles.
    task automatic ack(int n, logic [31:0] d);
        for (int i = 0; i < 50 && ram_req_o !== 1'b1; i++) @(posedge clk_i);
        if (ram_req_o !== 1'b1) begin
            fails++;
            give_verdict();
        end
        repeat (n + 1) @(posedge clk_i);
        ram_ack_i   <= 1'b1;
        ram_rdata_i <= d;
        @(posedge clk_i);
        ram_ack_i   <= 1'b0;
        ram_rdata_i <= ~d;
        #1 check("ready", flag, 1'b1);
    endtask

    // Software polls the ready bit before it takes a read result.
    task automatic poll();
        v = '0;
        for (int i = 0; i < 50 && v[READY_BIT] !== 1'b1; i++) begin
            rd(OFS_SELECT);
        end
        if (v[READY_BIT] !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        logic [7:0]  o [5] = '{OFS_SELECT, OFS_COMMAND, OFS_ADDRESS,
                               OFS_WORD, 8'h00};
        logic [31:0] e [5] = '{32'h8000_0000, 0, 0, 0, 0};
        for (int i = 0; i < 5; i++) begin
            rd(o[i]);
            check("reset", v, e[i]);
        end
    endtask

    task automatic t_write();
        wr(OFS_SELECT, {28'h0, SEL_VLAN_HASH});
        wr(OFS_ADDRESS, 32'hFFFF_FFFF);
        rd(OFS_ADDRESS);
        check("address", v, 32'h0000_3FFF);
        wr(OFS_WORD, 32'hA5C3_0F1E);
        wr(OFS_COMMAND, 32'h1);
        check("busy", flag, 1'b0);
        check("ram cmd", {ram_req_o, ram_cmd_o},
              {1'b1, 1'b1, SEL_VLAN_HASH, 14'h3FFF, 32'hA5C3_0F1E});
        ack(3, 32'h0);
        rd(OFS_COMMAND);
        check("command", v, 32'h1);
    endtask

    task automatic t_read_busy();
        wr(OFS_ADDRESS, 32'h0000_0123);
        wr(OFS_COMMAND, 32'h0);
        wr(OFS_WORD, 32'h1111_1111);
        wr(OFS_COMMAND, 32'h1);
        wr(OFS_ADDRESS, 32'h5);
        rd(OFS_SELECT);
        check("busy select", v, 32'h1);
        check("ram cmd", ram_cmd_o,
              {1'b0, SEL_VLAN_HASH, 14'h0123, 32'hA5C3_0F1E});
        ack(0, 32'hDEAD_BEEF);
        poll();
        rd(OFS_WORD);
        check("read word", v, 32'hDEAD_BEEF);
        rd(OFS_ADDRESS);
        check("address kept", v, 32'h123);
        check("one access", ram_req_o, 1'b0);
    endtask

    // Reserved codes make no request; only a read loads a zero word.
    task automatic t_reserved();
        wr(OFS_SELECT, {28'h0, 4'hF});
        wr(OFS_COMMAND, 32'h1);
        check("reserved write", {flag, ram_req_o}, 2'b00);
        rd(OFS_WORD);
        check("word untouched", v, 32'hDEAD_BEEF);
        wr(OFS_SELECT, {28'h0, SEL_RESERVED6});
        wr(OFS_COMMAND, 32'h0);
        check("reserved", {flag, ram_req_o}, 2'b00);
        @(posedge clk_i);
        #1 check("reserved done", flag, 1'b1);
        rd(OFS_WORD);
        check("reserved word", v, 32'h0);
    endtask

    // A low clock enable freezes the port, so a write meanwhile is lost.
    task automatic t_freeze();
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(OFS_ADDRESS, 32'h0000_0ABC);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd(OFS_ADDRESS);
        check("frozen address", v, 32'h0000_0123);
    endtask

    // ==========================================================
    // Main sequence and hang guard
    // ==========================================================
    initial begin
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_write();
        t_read_busy();
        t_reserved();
        t_freeze();
        give_verdict();
    end

    initial begin
        #100us;
        fails++;
        give_verdict();
    end
endmodule // test_indirect_ram_access_port
